// file: shared/lsf_pkg.sv
package lsf_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_RESULT = 6'h00;
  localparam logic [5:0] IDX_CONFIG = 6'h01;
  localparam logic [5:0] IDX_LOW_LIMIT = 6'h02;
  localparam logic [5:0] IDX_HIGH_LIMIT = 6'h03;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h04;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h05;
  localparam logic [1:0] WORD_LANE = 2'h0;

  localparam logic [3:0] RANGE_AUTO = 4'hc;
  localparam logic [3:0] RANGE_MAX = 4'hb;
  localparam logic [3:0] RANGE_MIN = 4'h0;

  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;

  localparam logic [1:0] FC_ONE = 2'h0;
  localparam logic [1:0] FC_TWO = 2'h1;
  localparam logic [1:0] FC_FOUR = 2'h2;
  localparam logic [3:0] NEED_ONE = 4'h1;
  localparam logic [3:0] NEED_TWO = 4'h2;
  localparam logic [3:0] NEED_FOUR = 4'h4;
  localparam logic [3:0] NEED_EIGHT = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_STEP = 4'h1;

  localparam logic [15:0] CONFIG_RESET = 16'hc810;
  localparam logic [15:0] LOW_LIMIT_RESET = 16'h0000;
  localparam logic [15:0] HIGH_LIMIT_RESET = 16'hffff;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // interrupt status / mask bit positions
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_OVF = 1;
  localparam int unsigned IRQ_HIGH = 2;
  localparam int unsigned IRQ_LOW = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

  typedef struct packed {
    logic [3:0] range_select;
    logic long_conv;
    logic [1:0] mode;
    logic overflow_flag;
    logic conversion_ready_flag;
    logic high_limit_flag;
    logic low_limit_flag;
    logic latch;
    logic polarity;
    logic mask_exp;
    logic [1:0] fault_count_select;
  } lsf_cfg_t;

  typedef struct packed {
    logic [3:0] expo;
    logic [11:0] mant;
  } lsf_meas_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_RUN = 2'b11
  } lsf_state_t;

  function automatic logic [3:0] lsf_need(input logic [1:0] fc);
    case (fc)
      FC_ONE: lsf_need = NEED_ONE;
      FC_TWO: lsf_need = NEED_TWO;
      FC_FOUR: lsf_need = NEED_FOUR;
      default: lsf_need = NEED_EIGHT;
    endcase
  endfunction

  // linear value, mantissa scaled by the exponent; reserved exponents clip
  function automatic logic [22:0] lsf_linear(input lsf_meas_t m);
    logic [3:0] e;
    e = (m.expo > RANGE_MAX) ? RANGE_MAX : m.expo;
    lsf_linear = {11'h000, m.mant} << e;
  endfunction

endpackage

// file: logic/lsf_flags.sv
`timescale 1ns/10ps
module lsf_flags
  import lsf_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic IRQ_O,
  output logic CONV_START_O,
  output logic CONV_ABORT_O,
  output logic [3:0] CONV_RANGE_O,
  output logic CONV_LONG_O,
  input wire logic CONV_DONE_I,
  input wire logic CONV_OVERLOAD_I,
  input wire logic [11:0] CONV_MANT_I
);

  lsf_cfg_t cfg_r;
  lsf_meas_t result_r;
  logic [15:0] low_lim_r;
  logic [15:0] high_lim_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  lsf_state_t state_r;
  logic [3:0] cur_range_r;
  logic [3:0] high_cnt_r;
  logic [3:0] low_cnt_r;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic irq_r;
  logic start_r;
  logic abort_r;

  // bus access takes effect on the first access-phase edge; pready follows a cycle later
  logic acc;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [5:0] idx;
  lsf_cfg_t wr_cfg;

  assign acc = PSEL_I & PENABLE_I & ~pready_r;
  assign idx = PADDR_I[7:2];
  assign mapped = (PADDR_I[1:0] == WORD_LANE) && (idx <= IDX_IRQ_MASK);
  assign wr_en = acc & PWRITE_I & mapped;
  assign rd_en = acc & ~PWRITE_I & mapped;
  assign wr_cfg = lsf_cfg_t'(PWDATA_I[15:0]);

  logic cfg_wr;
  logic cfg_rd;
  assign cfg_wr = wr_en && (idx == IDX_CONFIG);
  assign cfg_rd = rd_en && (idx == IDX_CONFIG);

  // conversion outcome decode
  logic auto_mode;
  logic done_evt;
  logic step_up;
  logic finish;
  lsf_meas_t meas;
  logic [22:0] meas_lin;
  logic above;
  logic below;
  logic [3:0] high_cnt_nxt;
  logic [3:0] low_cnt_nxt;
  logic [3:0] need;

  assign auto_mode = (cfg_r.range_select == RANGE_AUTO);
  // a config write aborts the running conversion, so a done in that cycle is dropped
  assign done_evt = (state_r == ST_RUN) && CONV_DONE_I && !cfg_wr;
  assign step_up = done_evt && auto_mode && CONV_OVERLOAD_I && (cur_range_r < RANGE_MAX);
  assign finish = done_evt && !step_up;
  assign meas = '{expo: cur_range_r, mant: CONV_MANT_I};
  assign meas_lin = lsf_linear(meas);
  assign above = meas_lin > lsf_linear(lsf_meas_t'(high_lim_r));
  assign below = meas_lin < lsf_linear(lsf_meas_t'(low_lim_r));
  assign need = lsf_need(cfg_r.fault_count_select);
  // counters saturate at the largest need so they never wrap
  assign high_cnt_nxt = !above ? CNT_ZERO : (high_cnt_r >= NEED_EIGHT) ? NEED_EIGHT : high_cnt_r + CNT_STEP;
  assign low_cnt_nxt = !below ? CNT_ZERO : (low_cnt_r >= NEED_EIGHT) ? NEED_EIGHT : low_cnt_r + CNT_STEP;

  logic high_hit;
  logic low_hit;
  assign high_hit = high_cnt_nxt >= need;
  assign low_hit = low_cnt_nxt >= need;

  // sequencer
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_r <= ST_IDLE;
    end else if (cfg_wr) begin
      state_r <= (wr_cfg.mode == MODE_SHUTDOWN) ? ST_IDLE : ST_START;
    end else begin
      case (state_r)
        ST_IDLE: state_r <= ST_IDLE;
        ST_START: state_r <= ST_RUN;
        ST_RUN: begin
          if (step_up) begin
            state_r <= ST_START;
          end else if (finish) begin
            state_r <= (cfg_r.mode == MODE_SINGLE) ? ST_IDLE : ST_START;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // range used by the converter; auto ranging begins each measurement at the lowest range
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      cur_range_r <= RANGE_MIN;
    end else if (cfg_wr) begin
      cur_range_r <= (wr_cfg.range_select == RANGE_AUTO) ? RANGE_MIN : wr_cfg.range_select;
    end else if (step_up) begin
      cur_range_r <= cur_range_r + CNT_STEP;
    end else if (finish && auto_mode) begin
      cur_range_r <= RANGE_MIN;
    end
  end

  // converter strobes
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      start_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      start_r <= (state_r == ST_START) && !cfg_wr;
      abort_r <= (cfg_wr && state_r != ST_IDLE) || step_up;
    end
  end

  // configuration register: writable fields, mode self-clear and status flags
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      cfg_r <= lsf_cfg_t'(CONFIG_RESET);
    end else begin
      if (cfg_wr) begin
        cfg_r.range_select <= wr_cfg.range_select;
        cfg_r.long_conv <= wr_cfg.long_conv;
        cfg_r.mode <= wr_cfg.mode;
        cfg_r.latch <= wr_cfg.latch;
        cfg_r.polarity <= wr_cfg.polarity;
        cfg_r.mask_exp <= wr_cfg.mask_exp;
        cfg_r.fault_count_select <= wr_cfg.fault_count_select;
      end else if (finish && cfg_r.mode == MODE_SINGLE) begin
        cfg_r.mode <= MODE_SHUTDOWN;
      end
      if (finish) begin
        // auto: overload here means the largest range overflowed; manual: any overload counts
        cfg_r.overflow_flag <= CONV_OVERLOAD_I;
      end
      // set wins over clear
      if (finish) begin
        cfg_r.conversion_ready_flag <= 1'b1;
      end else if (cfg_rd || (cfg_wr && wr_cfg.mode != MODE_SHUTDOWN)) begin
        cfg_r.conversion_ready_flag <= 1'b0;
      end
      if (finish) begin
        // latched style holds a set flag until the config register is read
        if (high_hit) begin
          cfg_r.high_limit_flag <= 1'b1;
        end else if (!cfg_r.latch) begin
          cfg_r.high_limit_flag <= 1'b0;
        end
        if (low_hit) begin
          cfg_r.low_limit_flag <= 1'b1;
        end else if (!cfg_r.latch) begin
          cfg_r.low_limit_flag <= 1'b0;
        end
      end else if (cfg_rd && cfg_r.latch) begin
        cfg_r.high_limit_flag <= 1'b0;
        cfg_r.low_limit_flag <= 1'b0;
      end
    end
  end

  // fault counters; untouched by shutdown so a restart resumes the count
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      high_cnt_r <= CNT_ZERO;
      low_cnt_r <= CNT_ZERO;
    end else if (finish) begin
      high_cnt_r <= high_cnt_nxt;
      low_cnt_r <= low_cnt_nxt;
    end
  end

  // result and limit registers
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      result_r <= lsf_meas_t'(RESULT_RESET);
    end else if (finish) begin
      result_r <= meas;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      low_lim_r <= LOW_LIMIT_RESET;
      high_lim_r <= HIGH_LIMIT_RESET;
    end else begin
      if (wr_en && idx == IDX_LOW_LIMIT) begin
        low_lim_r <= PWDATA_I[15:0];
      end
      if (wr_en && idx == IDX_HIGH_LIMIT) begin
        high_lim_r <= PWDATA_I[15:0];
      end
    end
  end

  // interrupt status: sticky, cleared by reading it, new events win over the clear
  logic [IRQ_W-1:0] irq_evt;
  always_comb begin
    irq_evt = IRQ_RESET;
    irq_evt[IRQ_DONE] = finish;
    irq_evt[IRQ_OVF] = finish && CONV_OVERLOAD_I;
    irq_evt[IRQ_HIGH] = finish && high_hit;
    irq_evt[IRQ_LOW] = finish && low_hit;
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      irq_stat_r <= IRQ_RESET;
      irq_mask_r <= IRQ_RESET;
      irq_r <= 1'b0;
    end else begin
      if (rd_en && idx == IDX_IRQ_STATUS) begin
        irq_stat_r <= irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
      if (wr_en && idx == IDX_IRQ_MASK) begin
        irq_mask_r <= PWDATA_I[IRQ_W-1:0];
      end
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // read mux; exponent hidden in the result when masked under manual range
  lsf_meas_t rd_result;
  logic [31:0] rd_data;
  always_comb begin
    rd_result = result_r;
    if (cfg_r.mask_exp && !auto_mode) begin
      rd_result.expo = RANGE_MIN;
    end
    rd_data = 32'h0000_0000;
    case (idx)
      IDX_RESULT: rd_data[15:0] = rd_result;
      IDX_CONFIG: rd_data[15:0] = cfg_r;
      IDX_LOW_LIMIT: rd_data[15:0] = low_lim_r;
      IDX_HIGH_LIMIT: rd_data[15:0] = high_lim_r;
      IDX_IRQ_STATUS: rd_data[IRQ_W-1:0] = irq_stat_r;
      IDX_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask_r;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // apb answer: one wait state, data and error captured with the access
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= acc;
      if (acc) begin
        prdata_r <= (!PWRITE_I && mapped) ? rd_data : 32'h0000_0000;
        pslverr_r <= !mapped;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  assign PRDATA_O = prdata_r;
  assign PREADY_O = pready_r;
  assign PSLVERR_O = pslverr_r;
  assign IRQ_O = irq_r;
  assign CONV_START_O = start_r;
  assign CONV_ABORT_O = abort_r;
  assign CONV_RANGE_O = cur_range_r;
  assign CONV_LONG_O = cfg_r.long_conv;

endmodule

// file: verif/lsf_flags_props.sv
`timescale 1ns/10ps
module lsf_flags_props
  import lsf_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic CONV_START_O,
  input wire logic CONV_ABORT_O,
  input wire logic [3:0] CONV_RANGE_O,
  input wire logic CONV_DONE_I,
  input wire logic CONV_OVERLOAD_I
);
  logic cfg_wr;
  logic auto_r;
  // a done in a config write cycle is dropped, so it is excused
  assign cfg_wr = PSEL_I && PENABLE_I && PWRITE_I && !PREADY_O && PADDR_I == 8'h04;
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      auto_r <= 1'b1;
    end else if (cfg_wr) begin
      auto_r <= PWDATA_I[15:12] == RANGE_AUTO;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  chk_apb_answer: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
    else $error("ready late");
  chk_apb_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held");
  chk_apb_error: assert property (
    PREADY_O |-> PSLVERR_O == (PADDR_I[7:2] > IDX_IRQ_MASK || PADDR_I[1:0] != WORD_LANE))
    else $error("error flag wrong");
  chk_err_data: assert property (PSLVERR_O |-> PRDATA_O == 32'h0)
    else $error("error data nonzero");
  chk_range_step: assert property (
    CONV_DONE_I && CONV_OVERLOAD_I && auto_r && CONV_RANGE_O < RANGE_MAX && !cfg_wr
    |=> CONV_ABORT_O && CONV_RANGE_O == $past(CONV_RANGE_O) + 4'h1 ##1 CONV_START_O)
    else $error("no range step");
  chk_top_stop: assert property (CONV_DONE_I && CONV_RANGE_O == RANGE_MAX && !cfg_wr |=> !CONV_ABORT_O)
    else $error("abort at top range");
  chk_manual_keep: assert property (CONV_DONE_I && !auto_r && !cfg_wr |=> !CONV_ABORT_O)
    else $error("abort in manual range");
  chk_start_pulse: assert property (CONV_START_O |=> !CONV_START_O)
    else $error("start held");
endmodule
bind lsf_flags lsf_flags_props u_props (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CONV_START_O(CONV_START_O), .CONV_ABORT_O(CONV_ABORT_O),
  .CONV_RANGE_O(CONV_RANGE_O), .CONV_DONE_I(CONV_DONE_I), .CONV_OVERLOAD_I(CONV_OVERLOAD_I));

// file: verif/lsf_conv_model.sv
`timescale 1ns/10ps
module lsf_conv_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [11:0] mant_i,
  input wire logic [3:0] delay_i,
  output logic done_o,
  output logic ovl_o,
  output logic [11:0] mant_o
);
  int ovl_left = 0;
  int cnt = 0;
  logic busy = 0;
  initial begin
    done_o = 0;
    ovl_o = 0;
    mant_o = 0;
  end
  // outside done the data toggles, so a stale sample cannot pass
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    ovl_o <= ~ovl_o;
    mant_o <= ~mant_o;
    if (rst_i || abort_i) begin
      busy <= 1'b0;
    end else if (start_i) begin
      busy <= 1'b1;
      cnt <= delay_i;
    end else if (busy && cnt > 0) begin
      cnt <= cnt - 1;
    end else if (busy) begin
      busy <= 1'b0;
      done_o <= 1'b1;
      ovl_o <= ovl_left > 0;
      mant_o <= mant_i;
      ovl_left <= ovl_left - 1;
    end
  end
endmodule

// file: verif/lsf_flags_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module lsf_flags_bench;
  import lsf_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, rerr;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic pready, pslverr, irq, cstart, cabort, clong, cdone, covl;
  logic [3:0] crange, dly = 1;
  logic [11:0] cmant, mant_v = 0;
  int fail_count = 0, total_checks = 0, seed = 32'h80742ebc, hcnt = 0, lcnt = 0, starts = 0;
  longint hi_lin = 64'd4095 << 11, lo_lin = 0;
  lsf_flags dut (.CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .IRQ_O(irq), .CONV_START_O(cstart), .CONV_ABORT_O(cabort), .CONV_RANGE_O(crange),
    .CONV_LONG_O(clong), .CONV_DONE_I(cdone), .CONV_OVERLOAD_I(covl), .CONV_MANT_I(cmant));
  lsf_conv_model model (.clk_i(clk), .rst_i(rst), .start_i(cstart), .abort_i(cabort), .mant_i(mant_v),
    .delay_i(dly), .done_o(cdone), .ovl_o(covl), .mant_o(cmant));
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) starts <= starts + int'(cstart);
  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic conv(input logic [15:0] c, input logic [11:0] m, input int ov, input bit rd);
    int e;
    longint lin;
    model.ovl_left = ov;
    mant_v <= m;
    dly <= 4'(1 + $unsigned($random(seed)) % 12);
    apb(1'b1, 8'h04, {16'h0, c});
    do begin
      @(posedge clk);
    end while (!(cdone && (!covl || crange == RANGE_MAX || c[15:12] != RANGE_AUTO)));
    repeat (2) @(posedge clk);
    e = (c[15:12] != RANGE_AUTO) ? int'(c[15:12]) : (ov > 11) ? 11 : ov;
    lin = longint'(m) << e;
    hcnt = (lin > hi_lin) ? hcnt + 1 : 0;
    lcnt = (lin < lo_lin) ? lcnt + 1 : 0;
    if (rd) begin
      apb(1'b0, 8'h04, 0);
      `CHK("ovf", (c[15:12] == RANGE_AUTO) ? ov > 11 : ov > 0, rdat[8])
      `CHK("ready", 1, rdat[7])
      `CHK("mode", MODE_SHUTDOWN, rdat[10:9])
      `CHK("long", c[11], clong)
      `CHK("high", hcnt >= (1 << c[1:0]), rdat[6])
      `CHK("low", lcnt >= (1 << c[1:0]), rdat[5])
      apb(1'b0, 8'h00, 0);
      `CHK("result", {e[3:0], m}, rdat[15:0])
      apb(1'b0, 8'h04, 0);
      `CHK("ready clear", 0, rdat[7])
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h04, 0);
    `CHK("cfg reset", CONFIG_RESET, rdat[15:0])
    `CHK("long reset", 1, clong)
    apb(1'b0, 8'h18, 0);
    `CHK("unmapped", 1, rerr)
    for (int i = 0; i < 8; i++) begin
      conv({(i % 2 == 1) ? RANGE_AUTO : 4'($unsigned($random(seed)) % 12), 3'b001, 9'h000},
        12'($random(seed)), $unsigned($random(seed)) % 14, 1);
    end
    apb(1'b1, 8'h0c, 32'h100);
    apb(1'b1, 8'h08, 32'h80);
    hi_lin = 'h100;
    lo_lin = 'h80;
    for (int f = 0; f < 4; f++) begin
      conv({RANGE_AUTO, 3'b001, 7'h0, f[1:0]}, 12'h010, 0, 1);
      for (int k = 0; k < (1 << f); k++) conv({RANGE_AUTO, 3'b001, 7'h0, f[1:0]}, 12'h200, 0, 1);
    end
    // latched style: an in-window result must not drop a set high flag
    conv(16'hc210, 12'h200, 0, 0);
    conv(16'hc210, 12'h0a0, 0, 0);
    apb(1'b0, 8'h04, 0);
    `CHK("high latched", 1, rdat[6])
    apb(1'b0, 8'h04, 0);
    `CHK("high read clear", 0, rdat[6])
    conv(16'hc200, 12'h200, 0, 0);
    apb(1'b1, 8'h04, 32'hc000);
    apb(1'b0, 8'h04, 0);
    `CHK("ready kept", 1, rdat[7])
    `CHK("high kept", 1, rdat[6])
    apb(1'b1, 8'h04, 32'hc200);
    apb(1'b0, 8'h04, 0);
    `CHK("ready by write", 0, rdat[7])
    apb(1'b1, 8'h04, 32'hc000);
    apb(1'b0, 8'h10, 0);
    apb(1'b1, 8'h14, 32'h1);
    `CHK("irq idle", 0, irq)
    conv(16'hc200, 12'h020, 0, 0);
    `CHK("irq done", 1, irq)
    apb(1'b0, 8'h10, 0);
    `CHK("status done", 1, rdat[0])
    repeat (3) @(posedge clk);
    `CHK("irq cleared", 0, irq)
    for (int md = 2; md < 4; md++) begin
      starts = 0;
      apb(1'b1, 8'h04, {16'h0, RANGE_AUTO, 1'b0, md[1:0], 9'h000});
      repeat (150) @(posedge clk);
      `CHK("continuous", 1, starts > 2)
    end
    apb(1'b1, 8'h04, 32'hc000);
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule
